/* test/mbwh_handler_props.sv */
`timescale 1ns/10ps
`default_nettype none
module mbwh_handler_props
	import mbwh_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        tcpMode,
	// Request stream
	input wire logic        rqValid,
	input wire logic        rqLast,
	input wire logic        rqReady,
	// Reply stream
	input wire logic        rspValid,
	input wire logic [7:0]  rspByte,
	input wire logic        rspLast,
	input wire logic        rspReady,
	// Loop side
	input wire logic        wrValid,
	input wire logic [1:0]  wrSection,
	input wire logic [13:0] wrAddr,
	input wire logic [15:0] wrData,
	input wire logic        wrReady,
	input wire logic        ctrlPulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Handshake steps
	sequence s_lastIn; rqValid && rqReady && rqLast; endsequence
	sequence s_fwd; wrValid && wrReady; endsequence
	sequence s_rspEnd; rspValid && rspReady && rspLast; endsequence
	property p_rspHold;
		rspValid && !rspReady |=> rspValid && $stable(rspByte) && $stable(rspLast);
	endproperty
	property p_wrHold;
		wrValid && !wrReady |=> wrValid && $stable({wrSection, wrAddr, wrData});
	endproperty
	property p_pulseOn; s_fwd ##0 wrData != 16'h0000 |=> ctrlPulse; endproperty
	property p_pulseOff; s_fwd ##0 wrData == 16'h0000 |=> !ctrlPulse; endproperty
	property p_pulseOne; $rose(ctrlPulse) |-> $past(wrValid) && $past(wrReady) ##1 !ctrlPulse; endproperty
	property p_answer; s_lastIn ##0 tcpMode |=> !rspValid ##1 rspValid; endproperty
	property p_busy; s_lastIn ##0 tcpMode |=> !rqReady [*3]; endproperty
	property p_end; s_rspEnd |=> !rspValid ##1 rqReady; endproperty
	property p_noRx; rspValid |-> !rqReady; endproperty
	a_rspHold: assert property (p_rspHold)
		else $error("reply byte changed while stalled");
	a_wrHold: assert property (p_wrHold)
		else $error("forwarded write changed while stalled");
	a_pulseOn: assert property (p_pulseOn)
		else $error("no pulse after nonzero write");
	a_pulseOff: assert property (p_pulseOff)
		else $error("pulse after zero write");
	a_pulseOne: assert property (p_pulseOne)
		else $error("pulse without forward or too long");
	a_answer: assert property (p_answer)
		else $error("reply not started two cycles after frame");
	a_busy: assert property (p_busy)
		else $error("request taken during reply");
	a_end: assert property (p_end)
		else $error("reply end sequence wrong");
	a_noRx: assert property (p_noRx)
		else $error("ready while replying");
endmodule
bind mbwh_handler mbwh_handler_props u_props (.ref_clk, .rstn, .tcpMode, .rqValid, .rqLast,
	.rqReady, .rspValid, .rspByte, .rspLast, .rspReady, .wrValid, .wrSection, .wrAddr,
	.wrData, .wrReady, .ctrlPulse);
`default_nettype wire

/* test/mbwh_handler_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mbwh_consts.svh"
module mbwh_handler_tb
	import mbwh_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rstn;
	logic        tcpMode;
	logic        available;
	logic [15:0] filterTime;
	logic        wrReady;
	wire logic   rqValid, rqLast, rqReady, rspValid, rspLast, rspReady, wrValid, ctrlPulse;
	wire logic [7:0]  rqByte, rspByte;
	wire logic [1:0]  wrSection;
	wire logic [13:0] wrAddr;
	wire logic [15:0] wrData;
	logic [31:0] fw[$]; // Forwarded entries
	int          error_cnt = 0;
	int          compares = 0;
	int          pulses = 0; // Control pulse cycles seen
	always #20 ref_clk = ~ref_clk;
	mbwh_handler dut (.ref_clk, .rstn, .baseAddr(8'h20), .tcpMode, .available, .filterTime,
		.hwVersion(16'h1234), .swVersion(16'hABCD), .rqValid, .rqByte, .rqLast, .rqReady,
		.rspValid, .rspByte, .rspLast, .rspReady, .wrValid, .wrSection, .wrAddr, .wrData,
		.wrReady, .ctrlPulse);
	mbwh_host_model host (.ref_clk, .rqValid, .rqByte, .rqLast, .rqReady, .rspValid,
		.rspByte, .rspLast, .rspReady);
	// Record every accepted forward
	always @(posedge ref_clk)
		if (wrValid && wrReady)
			fw.push_back({wrSection, wrAddr, wrData});
	// Count cycles with the control pulse high
	always @(posedge ref_clk)
		if (ctrlPulse)
			pulses++;
	// ------
	// Checks
	// ------
	task chk(input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (a !== e)
		begin
			error_cnt++;
			$display("Error %0t: got %h exp %h", $time, a, e);
		end
	endtask
	task chk_rsp(input logic [7:0] e[$]);
		chk(host.got.size(), e.size());
		foreach (e[i])
			chk(host.got[i], e[i]);
	endtask
	task wait_rsp(input int n);
		for (int k = 0; k < 400 && host.got.size() < n; k++)
			@(posedge ref_clk);
	endtask
	task xfer(input logic [7:0] f[$], input logic [7:0] e[$]);
		host.send(f);
		wait_rsp(e.size());
		chk_rsp(e);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// ------
	// Scenarios
	// ------
	task t_sid;
		host.slow = 1'b1;
		xfer({8'h20, 8'h11}, {8'h20, 8'h11, 8'h06, `MBWH_SLAVE_ID, 8'hFF,
			8'h12, 8'h34, 8'hAB, 8'hCD});
		host.slow = 1'b0;
		$display("t_sid done");
	endtask
	task t_id;
		logic [7:0] e[$];
		string      s[3];
		s = '{`MBWH_STR_VENDOR, `MBWH_STR_PROD, `MBWH_STR_REV};
		e = {8'h20, 8'h2B, 8'h0E, 8'h01, 8'h01, 8'h00, 8'h00, 8'h03};
		for (int i = 0; i < 3; i++)
		begin
			e.push_back(8'(i));
			e.push_back(8'(s[i].len()));
			for (int k = 0; k < s[i].len(); k++)
				e.push_back(s[i][k]);
		end
		xfer({8'h20, 8'h2B, 8'h0E, 8'h01, 8'h00}, e);
		e = {8'h20, 8'h2B, 8'h0E, 8'h04, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'(s[2].len())};
		for (int k = 0; k < s[2].len(); k++)
			e.push_back(s[2][k]);
		xfer({8'h20, 8'h2B, 8'h0E, 8'h04, 8'h02}, e);
		for (int i = 2; i < 4; i++)
			xfer({8'h20, 8'h2B, 8'h0E, 8'(i), 8'h00}, {8'h20, 8'hAB, 8'h03});
		xfer({8'h20, 8'h2B, 8'h0E, 8'h04, 8'h03}, {8'h20, 8'hAB, 8'h02});
		xfer({8'h20, 8'h2B, 8'h0D, 8'h01, 8'h00}, {8'h20, 8'hAB, 8'h01});
		$display("t_id done");
	endtask
	task t_exc;
		logic [7:0] f[$];
		fw.delete();
		xfer({8'h20, 8'h41}, {8'h20, 8'hC1, 8'h01});
		xfer({8'h20, 8'h11, 8'h00}, {8'h20, 8'h91, 8'h01});
		// Full-length frame for 124 registers, so only the count is wrong
		f = {8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h7C, 8'hF8};
		repeat (248) f.push_back(8'h00);
		xfer(f, {8'h20, 8'h90, 8'h02});
		xfer({8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h20, 8'h90, 8'h03});
		xfer({8'h20, 8'h0F, 8'h3D, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
			{8'h20, 8'h8F, 8'h02});
		xfer({8'h20, 8'h10, 8'h00, 8'hFF, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02},
			{8'h20, 8'h90, 8'h02});
		xfer({8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01},
			{8'h20, 8'h90, 8'h03});
		chk(fw.size(), 0);
		$display("t_exc done");
	endtask
	task t_write;
		fw.delete();
		host.send({8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00});
		wait_rsp(6);
		chk(fw.size(), 0);
		chk_rsp({8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02});
		repeat (20) @(posedge ref_clk);
		chk(fw[0], {2'd0, 14'h0100, 16'h0001});
		chk(fw[1], {2'd0, 14'h0101, 16'h0000});
		chk(pulses, 1);
		#1 wrReady = 1'b0;
		xfer({8'h21, 8'h0F, 8'h01, 8'h05, 8'h00, 8'h01, 8'h02, 8'h00, 8'hFF},
			{8'h21, 8'h0F, 8'h01, 8'h05, 8'h00, 8'h01});
		repeat (10) @(posedge ref_clk);
		#1 wrReady = 1'b1;
		repeat (6) @(posedge ref_clk);
		chk(fw[2], {2'd1, 14'h0105, 16'h00FF});
		$display("t_write done");
	endtask
	task t_gate;
		#1 tcpMode = 1'b1;
		xfer({8'h30, 8'h11}, {8'h30, 8'h91, 8'h0A});
		available = 1'b0;
		xfer({8'h20, 8'h11}, {8'h20, 8'h91, 8'h0A});
		available = 1'b1;
		tcpMode = 1'b0;
		host.send({8'h30, 8'h11});
		repeat (20) @(posedge ref_clk);
		chk(host.got.size(), 0);
		$display("t_gate done");
	endtask
	task t_filter;
		logic [7:0] w[$];
		logic [7:0] r[$];
		fw.delete();
		#1 filterTime = 16'd100;
		w = {8'h20, 8'h10, 8'h01, 8'h20, 8'h00, 8'h01, 8'h02, 8'h00, 8'h07};
		r = {8'h20, 8'h10, 8'h01, 8'h20, 8'h00, 8'h01};
		xfer(w, r);
		xfer(w, r);
		repeat (10) @(posedge ref_clk);
		chk(fw.size(), 1);
		repeat (110) @(posedge ref_clk);
		xfer(w, r);
		repeat (10) @(posedge ref_clk);
		chk(fw.size(), 2);
		#1 filterTime = 16'd0;
		$display("t_filter done");
	endtask
	task t_room;
		logic [7:0] f[$];
		logic [7:0] g[$];
		fw.delete();
		wrReady = 1'b0;
		f = {8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h7B, 8'hF6};
		for (int i = 1; i <= 123; i++)
			f = {f, 8'h00, 8'(i)};
		xfer(f, {8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h7B});
		g = {8'h20, 8'h10, 8'h02, 8'h00, 8'h00, 8'h07, 8'h0E};
		repeat (14) g.push_back(8'h01);
		xfer(g, {8'h20, 8'h90, 8'h06});
		wrReady = 1'b1;
		for (int i = 0; i < 1000 && fw.size() < 123; i++)
			@(posedge ref_clk);
		#1;
		for (int i = 0; i < 123; i++)
			chk(fw[i], {2'd0, 14'(16'h0100 + i), 16'(i + 1)});
		xfer(g, {8'h20, 8'h10, 8'h02, 8'h00, 8'h00, 8'h07});
		$display("t_room done");
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Reset, then run every scenario
	initial
	begin
		rstn = 1'b0;
		tcpMode = 1'b0;
		available = 1'b1;
		filterTime = 16'd0;
		wrReady = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 rstn = 1'b1;
		t_sid;
		t_id;
		t_exc;
		t_write;
		t_gate;
		t_filter;
		t_room;
		print_verdict;
	end
	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		print_verdict;
	end
endmodule
`default_nettype wire

/* test/mbwh_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mbwh_host_model
	import mbwh_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Request stream
	output var  logic       rqValid,
	output var  logic [7:0] rqByte,
	output var  logic       rqLast,
	input  wire logic       rqReady,
	// Reply stream
	input  wire logic       rspValid,
	input  wire logic [7:0] rspByte,
	input  wire logic       rspLast,
	output var  logic       rspReady
);
	logic [7:0] got[$]; // Reply bytes taken
	logic       slow;   // Drop reply ready every other cycle
	initial
	begin
		rqValid = 1'b0;
		rqByte = 8'h00;
		rqLast = 1'b0;
		rspReady = 1'b1;
		slow = 1'b0;
	end
	// Take reply bytes, then move ready off the edge
	always @(posedge ref_clk)
	begin
		if (rspValid && rspReady)
			got.push_back(rspByte);
		#1 rspReady = slow ? ~rspReady : 1'b1;
	end
	// Send one frame, holding each byte until taken
	task send(input logic [7:0] f[$]);
		got.delete();
		@(posedge ref_clk);
		#1;
		foreach (f[i])
		begin
			rqValid = 1'b1;
			rqByte = f[i];
			rqLast = (i == f.size() - 1);
			do @(posedge ref_clk); while (rqReady !== 1'b1);
			#1;
		end
		rqValid = 1'b0;
		rqLast = 1'b0;
		rqByte = ~rqByte; // Released line shows no stale byte
	endtask
endmodule
`default_nettype wire

/* verilog/mbwh_consts.svh */
`ifndef MBWH_CONSTS_SVH
`define MBWH_CONSTS_SVH
// ----------------------------------------
// Queue geometry
// ----------------------------------------
`define MBWH_DEPTH      8'h80
`define MBWH_IDX_W      7
`define MBWH_MAX_REGS   16'h007B
// ----------------------------------------
// Function codes and identification fields
// ----------------------------------------
`define MBWH_FN_COILS   8'h0F
`define MBWH_FN_REGS    8'h10
`define MBWH_FN_SID     8'h11
`define MBWH_FN_DEVID   8'h2B
`define MBWH_MEI_DEVID  8'h0E
`define MBWH_CODE_BASIC 8'h01
`define MBWH_CODE_ONE   8'h04
`define MBWH_CONFORM    8'h01
`define MBWH_NUM_OBJ    8'h03
`define MBWH_OBJ_LAST   8'h02
`define MBWH_SID_COUNT  8'h06
`define MBWH_RUN_ON     8'hFF
// Arbitrary slave identifier value
`define MBWH_SLAVE_ID   8'h5A
// ----------------------------------------
// Exception codes
// ----------------------------------------
`define MBWH_EXC_FLAG   8'h80
`define MBWH_EXC_FUNC   8'h01
`define MBWH_EXC_ADDR   8'h02
`define MBWH_EXC_VALUE  8'h03
`define MBWH_EXC_BUSY   8'h06
`define MBWH_EXC_GATE   8'h0A
// ----------------------------------------
// Database layout and frame lengths
// ----------------------------------------
`define MBWH_MS_REGS    16'h0100
`define MBWH_DB_LAST    16'h3CFF
`define MBWH_SECTIONS   8'h04
`define MBWH_HDR_WR     16'h0007
`define MBWH_LEN_SID    16'h0002
`define MBWH_LEN_DEVID  16'h0005
`define MBWH_TX_EXC     6'h03
`define MBWH_TX_WR      6'h06
`define MBWH_TX_SID     6'h09
`define MBWH_TX_IDHDR   6'h08
// ----------------------------------------
// Identification strings (arbitrary values)
// ----------------------------------------
`define MBWH_STR_VENDOR "VENDOR"
`define MBWH_STR_PROD   "GATEWAY"
`define MBWH_STR_REV    "V1.00"
`define MBWH_LEN_VENDOR 6'h06
`define MBWH_LEN_PROD   6'h07
`define MBWH_LEN_REV    6'h05
`endif

/* verilog/mbwh_handler.sv */
// Contract
// R1: Coil and register writes hit same registers
// R2: Accept up to 123 registers per write
// R3: Queue writes, forward in order to units
// R4: Drop duplicate unit commands within filter time
// R5: Host keeps write rate below forwarding rate
// R6: Outputs pulse; off commands still forwarded
// R7: Slave ID reply: 6, id, 255, versions
// R8: Decode function, MEI, read code, object
// R9: Basic category only: codes 01 and 04
// R10: Objects are vendor, product, revision strings
// R11: Identification reply header then object triples
// R12: Exception 01 for bad function or length
// R13: Exception 02 for bad address or count
// R14: Exception 03 for illegal data value
// R15: Exception 06 when write buffer lacks room
// R16: Exception 0A when unavailable or unit mismatched; a mismatched unit gets 0A only with tcpMode, otherwise the frame gets no reply
// R17: Database of eight-parameter blocks, 32 each
// R18: Four sections reached by own slave address
// R19: Reply to host before forwarding writes
// R20: Exception reply: function with MSB, code
`timescale 1ns/10ps
`default_nettype none
`include "mbwh_consts.svh"
module mbwh_handler
	import mbwh_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Configuration
	input  wire logic [7:0]  baseAddr,
	input  wire logic        tcpMode,
	input  wire logic        available,
	input  wire logic [15:0] filterTime,
	input  wire logic [15:0] hwVersion,
	input  wire logic [15:0] swVersion,
	// Request byte stream
	input  wire logic        rqValid,
	input  wire logic [7:0]  rqByte,
	input  wire logic        rqLast,
	output logic             rqReady,
	// Reply byte stream
	output logic             rspValid,
	output logic [7:0]       rspByte,
	output logic             rspLast,
	input  wire logic        rspReady,
	// Forwarded writes toward the loop
	output logic             wrValid,
	output logic [1:0]       wrSection,
	output logic [13:0]      wrAddr,
	output logic [15:0]      wrData,
	input  wire logic        wrReady,
	output logic             ctrlPulse
);
	mbwh_st_type st_reg;   // Registered state
	mbwh_st_type st_next;  // Next state
	logic        memWe;    // Queue write strobe
	logic [31:0] memWdata; // Queue write entry
	logic [31:0] memRdata; // Queue read entry

	// ----------------------------------------
	// Identification string bytes
	// ----------------------------------------
	function automatic logic [7:0] objByte(input logic [1:0] o, input logic [5:0] k);
		logic [5:0] i;
		i = k - 6'h02;
		case (o)
			2'h0: objByte = (k == 6'h00) ? 8'h00 : (k == 6'h01) ? {2'b00, `MBWH_LEN_VENDOR} :
				8'(`MBWH_STR_VENDOR >> (8 * (`MBWH_LEN_VENDOR - 6'h01 - i))); // R10
			2'h1: objByte = (k == 6'h00) ? 8'h01 : (k == 6'h01) ? {2'b00, `MBWH_LEN_PROD} :
				8'(`MBWH_STR_PROD >> (8 * (`MBWH_LEN_PROD - 6'h01 - i))); // R10
			default: objByte = (k == 6'h00) ? 8'h02 : (k == 6'h01) ? {2'b00, `MBWH_LEN_REV} :
				8'(`MBWH_STR_REV >> (8 * (`MBWH_LEN_REV - 6'h01 - i))); // R10
		endcase
	endfunction

	// ----------------------------------------
	// Reply byte selection
	// ----------------------------------------
	function automatic logic [7:0] replyByte(input mbwh_st_type s, input logic [5:0] x);
		logic [5:0] j;
		j = x - `MBWH_TX_IDHDR;
		replyByte = 8'h00;
		if (x == 6'h00)
		begin
			replyByte = s.unit;
		end
		else
		begin
			case (s.kind)
				MBWH_K_EXC: replyByte = (x == 6'h01) ? (s.func | `MBWH_EXC_FLAG) : s.exc; // R20
				MBWH_K_WR:
				begin
					case (x) // Echo of start address and count
						6'h01: replyByte = s.func;
						6'h02: replyByte = s.addr[15:8];
						6'h03: replyByte = s.addr[7:0];
						6'h04: replyByte = s.qty[15:8];
						default: replyByte = s.qty[7:0];
					endcase
				end
				MBWH_K_SID:
				begin
					case (x) // R7
						6'h01: replyByte = `MBWH_FN_SID;
						6'h02: replyByte = `MBWH_SID_COUNT;
						6'h03: replyByte = `MBWH_SLAVE_ID;
						6'h04: replyByte = `MBWH_RUN_ON;
						6'h05: replyByte = hwVersion[15:8];
						6'h06: replyByte = hwVersion[7:0];
						6'h07: replyByte = swVersion[15:8];
						default: replyByte = swVersion[7:0];
					endcase
				end
				default:
				begin
					case (x) // R11
						6'h01: replyByte = `MBWH_FN_DEVID;
						6'h02: replyByte = `MBWH_MEI_DEVID;
						6'h03: replyByte = s.code;
						6'h04: replyByte = `MBWH_CONFORM;
						6'h05: replyByte = 8'h00;
						6'h06: replyByte = 8'h00;
						6'h07: replyByte = (s.code == `MBWH_CODE_ONE) ? 8'h01 : `MBWH_NUM_OBJ;
						default:
						begin
							if (s.code == `MBWH_CODE_ONE)
								replyByte = objByte(s.obj[1:0], j); // R9
							else if (j < `MBWH_LEN_VENDOR + 6'h02)
								replyByte = objByte(2'h0, j);
							else if (j < `MBWH_LEN_VENDOR + `MBWH_LEN_PROD + 6'h04)
								replyByte = objByte(2'h1, j - `MBWH_LEN_VENDOR - 6'h02);
							else
								replyByte = objByte(2'h2,
									j - `MBWH_LEN_VENDOR - `MBWH_LEN_PROD - 6'h04);
						end
					endcase
				end
			endcase
		end
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic [15:0] n;
		logic [15:0] q;
		logic [16:0] lastReg;
		logic [7:0]  offs;
		logic [7:0]  used;
		logic        isWr;
		logic [7:0]  fin;
		logic        dup;
		n = st_reg.rxCnt;
		q = {st_reg.qty[15:8], rqByte};
		lastReg = {1'b0, st_reg.addr} + {1'b0, q} - 17'h00001;
		offs = rqByte - baseAddr;
		used = st_reg.commitPtr - st_reg.readPtr;
		isWr = (st_reg.func == `MBWH_FN_COILS) || (st_reg.func == `MBWH_FN_REGS); // R1
		fin = 8'h00;
		dup = 1'b0;
		st_next = st_reg;
		st_next.pulse = 1'b0;
		memWe = 1'b0;
		memWdata = {st_reg.section, st_reg.addr[13:0] + st_reg.wrIdx[13:0],
			st_reg.dataHi, rqByte};
		// Request bytes, one per accepted beat
		if (st_reg.state == MBWH_RECV && rqValid)
		begin
			st_next.rxCnt = (n == 16'hFFFF) ? n : n + 16'h0001;
			case (n)
				16'h0000:
				begin
					st_next.unit = rqByte;
					st_next.func = 8'h00;
					st_next.exc = 8'h00;
					st_next.wrIdx = 16'h0000;
					st_next.section = offs[1:0]; // R18
					st_next.skip = (offs >= `MBWH_SECTIONS) && !tcpMode;
					st_next.gwBad = (offs >= `MBWH_SECTIONS) && tcpMode; // R16
				end
				16'h0001: st_next.func = rqByte;
				16'h0002:
				begin
					st_next.mei = rqByte; // R8
					st_next.addr[15:8] = rqByte;
				end
				16'h0003:
				begin
					st_next.code = rqByte; // R8
					st_next.addr[7:0] = rqByte;
				end
				16'h0004:
				begin
					st_next.obj = rqByte; // R8
					st_next.qty[15:8] = rqByte;
				end
				16'h0005:
				begin
					st_next.qty = q;
					if (isWr && st_reg.exc == 8'h00)
					begin
						if (q == 16'h0000)
							st_next.exc = `MBWH_EXC_VALUE; // R14
						else if (q > `MBWH_MAX_REGS)
							st_next.exc = `MBWH_EXC_ADDR; // R2 R13
						else if (lastReg > {1'b0, `MBWH_DB_LAST} || (st_reg.addr <
							`MBWH_MS_REGS && lastReg >= {1'b0, `MBWH_MS_REGS}))
							st_next.exc = `MBWH_EXC_ADDR; // R13 R17
						else if (q > {8'h00, `MBWH_DEPTH - used})
							st_next.exc = `MBWH_EXC_BUSY; // R15
					end
				end
				16'h0006:
				begin
					if (isWr && st_reg.exc == 8'h00 && {8'h00, rqByte} != {st_reg.qty[14:0], 1'b0})
						st_next.exc = `MBWH_EXC_VALUE; // R14
				end
				default:
				begin
					// Register data, high byte then low byte
					if (n[0])
						st_next.dataHi = rqByte;
					else if (isWr && st_reg.exc == 8'h00 && st_reg.wrIdx < st_reg.qty)
					begin
						memWe = 1'b1; // R3
						st_next.stagePtr = st_reg.stagePtr + 8'h01;
						st_next.wrIdx = st_reg.wrIdx + 16'h0001;
					end
				end
			endcase
			// End of frame: choose the reply
			if (rqLast)
			begin
				st_next.rxCnt = 16'h0000;
				if (!available || st_next.gwBad)
					fin = `MBWH_EXC_GATE; // R16
				else if (st_next.func == `MBWH_FN_COILS || st_next.func == `MBWH_FN_REGS)
					fin = (n + 16'h0001 != `MBWH_HDR_WR + {st_next.qty[14:0], 1'b0}) ?
						`MBWH_EXC_FUNC : st_next.exc; // R12
				else if (st_next.func == `MBWH_FN_SID)
					fin = (n + 16'h0001 != `MBWH_LEN_SID) ? `MBWH_EXC_FUNC : 8'h00; // R12
				else if (st_next.func == `MBWH_FN_DEVID)
				begin
					if (n + 16'h0001 != `MBWH_LEN_DEVID || st_next.mei != `MBWH_MEI_DEVID)
						fin = `MBWH_EXC_FUNC; // R12
					else if (st_next.code != `MBWH_CODE_BASIC && st_next.code != `MBWH_CODE_ONE)
						fin = `MBWH_EXC_VALUE; // R9
					else if (st_next.code == `MBWH_CODE_ONE && st_next.obj > `MBWH_OBJ_LAST)
						fin = `MBWH_EXC_ADDR; // R13
				end
				else
					fin = `MBWH_EXC_FUNC; // R12
				st_next.exc = fin;
				st_next.txIdx = 6'h00;
				if (st_next.skip || fin != 8'h00)
					st_next.stagePtr = st_reg.commitPtr;
				if (!st_next.skip)
					st_next.state = MBWH_RESP;
				if (fin != 8'h00)
				begin
					st_next.kind = MBWH_K_EXC;
					st_next.txLen = `MBWH_TX_EXC;
				end
				else if (st_next.func == `MBWH_FN_SID)
				begin
					st_next.kind = MBWH_K_SID;
					st_next.txLen = `MBWH_TX_SID;
				end
				else if (st_next.func == `MBWH_FN_DEVID)
				begin
					st_next.kind = MBWH_K_ID;
					st_next.txLen = (st_next.code == `MBWH_CODE_ONE) ? `MBWH_TX_IDHDR +
						6'h02 + ((st_next.obj == 8'h00) ? `MBWH_LEN_VENDOR : (st_next.obj ==
						8'h01) ? `MBWH_LEN_PROD : `MBWH_LEN_REV) : `MBWH_TX_IDHDR + 6'h06 +
						`MBWH_LEN_VENDOR + `MBWH_LEN_PROD + `MBWH_LEN_REV; // R11
				end
				else
				begin
					st_next.kind = MBWH_K_WR;
					st_next.txLen = `MBWH_TX_WR;
				end
			end
		end
		// Reply bytes out, register per byte
		if (st_reg.state == MBWH_RESP && (!st_reg.rspValid || rspReady))
		begin
			if (st_reg.txIdx < st_reg.txLen)
			begin
				st_next.rspValid = 1'b1;
				st_next.rspByte = replyByte(st_reg, st_reg.txIdx);
				st_next.rspLast = (st_reg.txIdx == st_reg.txLen - 6'h01);
				st_next.txIdx = st_reg.txIdx + 6'h01;
			end
			else
			begin
				// Reply taken: only now release writes to the loop
				st_next.rspValid = 1'b0;
				st_next.rspLast = 1'b0;
				st_next.commitPtr = st_reg.stagePtr; // R19
				st_next.state = MBWH_RECV;
			end
		end
		// Filter window count
		if (st_reg.filtCnt != 16'h0000)
			st_next.filtCnt = st_reg.filtCnt - 16'h0001;
		// Drain: fetch, filter, offer
		if (st_reg.rdPend)
		begin
			st_next.rdPend = 1'b0;
			dup = (memRdata == st_reg.lastEntry) && (st_reg.filtCnt != 16'h0000) &&
				({2'b00, memRdata[29:16]} >= `MBWH_MS_REGS); // R4
			if (!dup)
			begin
				st_next.outValid = 1'b1; // R3
				st_next.outEntry = memRdata;
			end
		end
		else if (!st_reg.outValid && st_reg.readPtr != st_reg.commitPtr)
		begin
			st_next.rdPend = 1'b1;
			st_next.readPtr = st_reg.readPtr + 8'h01; // R15
		end
		if (st_reg.outValid && wrReady)
		begin
			st_next.outValid = 1'b0;
			st_next.lastEntry = st_reg.outEntry;
			st_next.filtCnt = filterTime; // R4
			st_next.pulse = (st_reg.outEntry[15:0] != 16'h0000); // R6
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
			st_reg.state <= MBWH_RECV;
			st_reg.kind <= MBWH_K_EXC;
		end
		else
			st_reg <= st_next;
	end

	// Write queue memory
	mbwh_queue_mem uQueue (
		.ref_clk (ref_clk),
		.wrEn    (memWe),
		.wrAddr  (st_reg.stagePtr[6:0]),
		.wrData  (memWdata),
		.rdAddr  (st_reg.readPtr[6:0]),
		.rdData  (memRdata)
	);

	// Outputs
	assign rqReady   = (st_reg.state == MBWH_RECV);
	assign rspValid  = st_reg.rspValid;
	assign rspByte   = st_reg.rspByte;
	assign rspLast   = st_reg.rspLast;
	assign wrValid   = st_reg.outValid;
	assign wrSection = st_reg.outEntry[31:30];
	assign wrAddr    = st_reg.outEntry[29:16];
	assign wrData    = st_reg.outEntry[15:0];
	assign ctrlPulse = st_reg.pulse;
endmodule
`default_nettype wire

/* verilog/mbwh_pkg.sv */
`default_nettype none
`include "mbwh_consts.svh"
package mbwh_pkg;
	// Frame phase
	typedef enum logic [1:0] {
		MBWH_RECV = 2'b01,
		MBWH_RESP = 2'b10
	} mbwh_state_type;
	// Reply shape
	typedef enum logic [3:0] {
		MBWH_K_EXC = 4'b0001,
		MBWH_K_WR  = 4'b0010,
		MBWH_K_SID = 4'b0100,
		MBWH_K_ID  = 4'b1000
	} mbwh_kind_type;
	// Whole handler state
	typedef struct packed {
		mbwh_state_type state;
		mbwh_kind_type  kind;
		logic [15:0]    rxCnt;
		logic [7:0]     unit;
		logic [7:0]     func;
		logic [7:0]     mei;
		logic [7:0]     code;
		logic [7:0]     obj;
		logic [7:0]     exc;
		logic [7:0]     dataHi;
		logic           skip;
		logic           gwBad;
		logic [1:0]     section;
		logic [15:0]    addr;
		logic [15:0]    qty;
		logic [15:0]    wrIdx;
		logic [7:0]     stagePtr;
		logic [7:0]     commitPtr;
		logic [7:0]     readPtr;
		logic [5:0]     txIdx;
		logic [5:0]     txLen;
		logic           rspValid;
		logic           rspLast;
		logic [7:0]     rspByte;
		logic           rdPend;
		logic           outValid;
		logic [31:0]    outEntry;
		logic [31:0]    lastEntry;
		logic [15:0]    filtCnt;
		logic           pulse;
	} mbwh_st_type;
endpackage
`default_nettype wire

/* verilog/mbwh_queue_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module mbwh_queue_mem
	import mbwh_pkg::*;
(
	// Clock
	input  wire logic        ref_clk,
	// Write port
	input  wire logic        wrEn,
	input  wire logic [6:0]  wrAddr,
	input  wire logic [31:0] wrData,
	// Read port
	input  wire logic [6:0]  rdAddr,
	output var  logic [31:0] rdData
);
	// Queue storage, no reset needed
	logic [31:0] store [0:127];

	// Write and registered read
	always_ff @(posedge ref_clk)
	begin
		if (wrEn)
		begin
			store[wrAddr] <= wrData;
		end
		rdData <= store[rdAddr];
	end
endmodule
`default_nettype wire
